// >>> hw/coad_alu.sv
`timescale 1ns/1ps
module coad_alu (
    coad_alu_if.alu u // Operands in, result and flags out
);
    import coad_pkg::*;

    logic [DW:0] sum;
    logic [4:0] hs;
    logic ci;

    // Result, carries and accumulator write flag
    always_comb begin
        ci = (u.op == OP_ADC || u.op == OP_SBC) ? u.cin : 1'b0;
        sum = '0;
        hs = '0;
        u.res = u.m;
        u.c = u.cin;
        u.h = u.hin;
        u.wa = 1'b0;
        unique case (u.op)
            OP_LD: u.wa = 1'b1;
            OP_AND: begin
                u.res = u.a & u.m;
                u.wa = 1'b1;
            end
            OP_OR: begin
                u.res = u.a | u.m;
                u.wa = 1'b1;
            end
            OP_XOR: begin
                u.res = u.a ^ u.m;
                u.wa = 1'b1;
            end
            OP_BIT_CMP: u.res = u.a & u.m;
            OP_CP, OP_SUB, OP_SBC: begin
                sum = {1'b0, u.a} - {1'b0, u.m} - {{DW{1'b0}}, ci};
                u.res = sum[DW-1:0];
                u.c = sum[DW];
                u.wa = (u.op != OP_CP);
            end
            OP_ADD, OP_ADC: begin
                hs = {1'b0, u.a[3:0]} + {1'b0, u.m[3:0]} + {4'h0, ci};
                sum = {1'b0, u.a} + {1'b0, u.m} + {{DW{1'b0}}, ci};
                u.res = sum[DW-1:0];
                u.c = sum[DW];
                u.h = hs[4];
                u.wa = 1'b1;
            end
            OP_ZERO: begin
                u.res = '0;
                u.wa = 1'b1;
            end
            OP_LDX, OP_LDY, OP_BTJ, OP_JRI, OP_RET: u.res = u.m;
        endcase
        u.n = u.res[DW-1];
        u.z = (u.res == '0);
    end

endmodule : coad_alu

// >>> hw/coad_alu_if.sv
`timescale 1ns/1ps
interface coad_alu_if;
    import coad_pkg::*;
    coad_op_t op;
    logic [DW-1:0] a;
    logic [DW-1:0] m;
    logic cin;
    logic hin;
    logic [DW-1:0] res;
    logic h;
    logic n;
    logic z;
    logic c;
    logic wa;
    modport core(output op, a, m, cin, hin, input res, h, n, z, c, wa);
    modport alu(input op, a, m, cin, hin, output res, h, n, z, c, wa);
endinterface : coad_alu_if

// >>> hw/coad_core.sv
// Behaviour
// - Immediate instruction: opcode byte, then the literal operand byte.
// - Direct short: one address byte, operand at 00 to FF.
// - Direct long: two bytes after opcode form a 16-bit address.
// - Indexed: address is unsigned X or Y plus offset; no offset gives 00-FF.
// - Indexed short: one offset byte plus index, up to 1FE.
// - Indexed long: 16-bit offset from two bytes plus index.
// - Indirect: byte after opcode addresses a pointer read from memory.
// - Indirect short: one-byte pointer, operand at 00 to FF.
// - Indirect long: two-byte pointer read at the byte pointer address.
// - Bit compare ANDs A with memory, keeps A, updates N and Z.
// - Branch if bit clear: bit into carry, jump when bit is 0.
// - Branch if bit set: bit into carry, jump when bit is 1.
// - Two branches jump on interrupt pin high or low.
`timescale 1ns/1ps
module coad_core #(
    parameter logic [15:0] PC_START = coad_pkg::PC_RST // Reset fetch address
) (
    input wire logic clk, // Core clock, 250 MHz
    input wire logic reset, // Synchronous reset, active high
    input wire logic irq_pin, // External interrupt pin, asynchronous
    input wire logic [coad_pkg::DW-1:0] mem_rdata, // Read data, cycle after
    output logic [coad_pkg::AW-1:0] mem_addr, // Memory address
    output logic mem_rd, // Read strobe
    output logic mem_wr, // Write strobe
    output logic [coad_pkg::DW-1:0] mem_wdata, // Write data
    output logic [coad_pkg::DW-1:0] acc, // Accumulator
    output logic [coad_pkg::DW-1:0] cc // Condition codes
);
    import coad_pkg::*;

    coad_state_t state_r, state_nxt, ret_r, ret_nxt;
    logic [AW-1:0] pc_r, pc_nxt, addr_r, addr_nxt, ea_w, ea_v, off_w;
    logic [DW-1:0] sp_r, sp_nxt, a_r, a_nxt, x_r, x_nxt, y_r, y_nxt;
    logic [DW-1:0] cc_r, cc_nxt, ir_r, ir_nxt, tmp_r, tmp_nxt;
    logic [DW-1:0] wd_r, wd_nxt, opc, idx_w, and_w;
    logic [2:0] cnt_r, cnt_nxt;
    logic take_r, take_nxt, rd_r, rd_nxt, wr_r, wr_nxt, go, bit_w;
    logic irq_s1_r, irq_s2_r, irq_s3_r, irq_lvl_r, irq_lvl_nxt;
    coad_op_t op_w;
    coad_mode_t mode_w;
    coad_alu_if alu_bus ();

    // ------------------------------------------------------------
    // Decode and helpers
    // ------------------------------------------------------------
    assign opc = (state_r == S_OPC) ? mem_rdata : ir_r;
    assign op_w = coad_op_t'(opc[OP_HI:OP_LO]);
    assign mode_w = coad_mode_t'(opc[MODE_HI:0]);
    assign idx_w = opc[F_YSEL] ? y_r : x_r;
    assign bit_w = mem_rdata[ir_r[MODE_HI:0]];
    assign and_w = a_r & mem_rdata;

    // Offset for the index adder per fetch stage
    always_comb begin
        off_w = '0;
        if (state_r == S_A2) begin
            off_w = {tmp_r, mem_rdata};
        end else if (state_r == S_A1) begin
            off_w = {{(AW-DW){1'b0}}, mem_rdata};
        end
    end

    coad_ea_add #(.AW(AW), .IW(DW)) u_ea (
        .idx(idx_w),
        .off(off_w),
        .ea(ea_w)
    );

    assign alu_bus.op = op_w;
    assign alu_bus.a = a_r;
    assign alu_bus.m = mem_rdata;
    assign alu_bus.cin = cc_r[CC_C];
    assign alu_bus.hin = cc_r[CC_H];

    coad_alu u_alu (
        .u(alu_bus.alu)
    );

    // ------------------------------------------------------------
    // Interrupt pin synchroniser and filter
    // ------------------------------------------------------------
    always_comb begin
        irq_lvl_nxt = (irq_s2_r == irq_s3_r) ? irq_s3_r : irq_lvl_r;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_s1_r <= 1'b0;
            irq_s2_r <= 1'b0;
            irq_s3_r <= 1'b0;
            irq_lvl_r <= 1'b0;
        end else begin
            irq_s1_r <= irq_pin;
            irq_s2_r <= irq_s1_r;
            irq_s3_r <= irq_s2_r;
            irq_lvl_r <= irq_lvl_nxt;
        end
    end

    // ------------------------------------------------------------
    // Fetch, address and execute sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        ret_nxt = ret_r;
        pc_nxt = pc_r;
        sp_nxt = sp_r;
        a_nxt = a_r;
        x_nxt = x_r;
        y_nxt = y_r;
        cc_nxt = cc_r;
        ir_nxt = ir_r;
        tmp_nxt = tmp_r;
        take_nxt = take_r;
        cnt_nxt = cnt_r;
        rd_nxt = 1'b0;
        wr_nxt = 1'b0;
        addr_nxt = addr_r;
        wd_nxt = wd_r;
        go = 1'b0;
        ea_v = ea_w;
        unique case (state_r)
            S_FETCH: begin
                rd_nxt = 1'b1;
                addr_nxt = pc_r;
                pc_nxt = pc_r + 16'h0001;
                ret_nxt = S_OPC;
                state_nxt = S_WAIT;
            end
            S_WAIT: state_nxt = ret_r;
            S_OPC: begin
                ir_nxt = mem_rdata;
                if (op_w == OP_RET) begin
                    rd_nxt = 1'b1;
                    addr_nxt = {STK_HI, sp_r + 8'h01};
                    sp_nxt = sp_r + 8'h01;
                    cnt_nxt = POP_CC;
                    ret_nxt = S_POP;
                    state_nxt = S_WAIT;
                end else if (op_w == OP_ZERO && mode_w == M_IMM) begin
                    a_nxt = '0;
                    cc_nxt[CC_N] = 1'b0;
                    cc_nxt[CC_Z] = 1'b1;
                    state_nxt = S_FETCH;
                end else if (mode_w == M_IDX0 && op_w != OP_BTJ
                        && op_w != OP_JRI) begin
                    go = 1'b1;
                end else begin
                    rd_nxt = 1'b1;
                    addr_nxt = pc_r;
                    pc_nxt = pc_r + 16'h0001;
                    take_nxt = irq_lvl_r ^ mem_rdata[F_JR_LOW];
                    state_nxt = S_WAIT;
                    if (op_w == OP_JRI) begin
                        ret_nxt = S_REL;
                    end else if (mode_w == M_IMM && op_w != OP_BTJ) begin
                        ret_nxt = S_EXEC;
                    end else begin
                        ret_nxt = S_A1;
                    end
                end
            end
            S_A1: begin
                tmp_nxt = mem_rdata;
                if (op_w == OP_BTJ) begin
                    rd_nxt = 1'b1;
                    addr_nxt = {{(AW-DW){1'b0}}, mem_rdata};
                    ret_nxt = S_BIT;
                    state_nxt = S_WAIT;
                end else begin
                    unique case (mode_w)
                        M_DIRL, M_IDXL: begin
                            rd_nxt = 1'b1;
                            addr_nxt = pc_r;
                            pc_nxt = pc_r + 16'h0001;
                            ret_nxt = S_A2;
                            state_nxt = S_WAIT;
                        end
                        M_INDS, M_INDL: begin
                            rd_nxt = 1'b1;
                            addr_nxt = {{(AW-DW){1'b0}}, mem_rdata};
                            ret_nxt = S_P1;
                            state_nxt = S_WAIT;
                        end
                        M_IDXS: go = 1'b1;
                        default: begin
                            go = 1'b1;
                            ea_v = {{(AW-DW){1'b0}}, mem_rdata};
                        end
                    endcase
                end
            end
            S_A2: begin
                go = 1'b1;
                if (mode_w == M_DIRL) begin
                    ea_v = {tmp_r, mem_rdata};
                end
            end
            S_P1: begin
                if (mode_w == M_INDL) begin
                    rd_nxt = 1'b1;
                    addr_nxt = {{(AW-DW){1'b0}}, tmp_r} + 16'h0001;
                    tmp_nxt = mem_rdata;
                    ret_nxt = S_P2;
                    state_nxt = S_WAIT;
                end else begin
                    go = 1'b1;
                    ea_v = {{(AW-DW){1'b0}}, mem_rdata};
                end
            end
            S_P2: begin
                go = 1'b1;
                ea_v = {tmp_r, mem_rdata};
            end
            S_EXEC: begin
                if (alu_bus.wa) begin
                    a_nxt = alu_bus.res;
                end
                if (op_w == OP_LDX) begin
                    x_nxt = mem_rdata;
                end
                if (op_w == OP_LDY) begin
                    y_nxt = mem_rdata;
                end
                cc_nxt[CC_H] = alu_bus.h;
                cc_nxt[CC_N] = alu_bus.n;
                cc_nxt[CC_Z] = alu_bus.z;
                cc_nxt[CC_C] = alu_bus.c;
                state_nxt = S_FETCH;
            end
            S_BIT: begin
                cc_nxt[CC_C] = bit_w;
                take_nxt = (bit_w == ir_r[F_SENSE]);
                rd_nxt = 1'b1;
                addr_nxt = pc_r;
                pc_nxt = pc_r + 16'h0001;
                ret_nxt = S_REL;
                state_nxt = S_WAIT;
            end
            S_REL: begin
                if (take_r) begin
                    pc_nxt = pc_r + {{(AW-DW){mem_rdata[DW-1]}}, mem_rdata};
                end
                state_nxt = S_FETCH;
            end
            S_POP: begin
                unique case (cnt_r)
                    POP_CC: cc_nxt = mem_rdata;
                    POP_A: a_nxt = mem_rdata;
                    POP_X: x_nxt = mem_rdata;
                    POP_PCH: pc_nxt = {mem_rdata, pc_r[DW-1:0]};
                    default: pc_nxt = {pc_r[AW-1:DW], mem_rdata};
                endcase
                if (cnt_r == POP_LAST) begin
                    state_nxt = S_FETCH;
                end else begin
                    rd_nxt = 1'b1;
                    addr_nxt = {STK_HI, sp_r + 8'h01};
                    sp_nxt = sp_r + 8'h01;
                    cnt_nxt = cnt_r + 3'h1;
                    state_nxt = S_WAIT;
                end
            end
        endcase
        // Operand address ready: clear writes, others read
        if (go) begin
            addr_nxt = ea_v;
            if (op_w == OP_ZERO) begin
                wr_nxt = 1'b1;
                wd_nxt = '0;
                cc_nxt[CC_N] = 1'b0;
                cc_nxt[CC_Z] = 1'b1;
                state_nxt = S_FETCH;
            end else begin
                rd_nxt = 1'b1;
                ret_nxt = S_EXEC;
                state_nxt = S_WAIT;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= S_FETCH;
            ret_r <= S_FETCH;
            pc_r <= PC_START;
            sp_r <= SP_RST;
            a_r <= '0;
            x_r <= '0;
            y_r <= '0;
            cc_r <= CC_RST;
            ir_r <= '0;
            tmp_r <= '0;
            take_r <= 1'b0;
            cnt_r <= POP_CC;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= '0;
            wd_r <= '0;
        end else begin
            state_r <= state_nxt;
            ret_r <= ret_nxt;
            pc_r <= pc_nxt;
            sp_r <= sp_nxt;
            a_r <= a_nxt;
            x_r <= x_nxt;
            y_r <= y_nxt;
            cc_r <= cc_nxt;
            ir_r <= ir_nxt;
            tmp_r <= tmp_nxt;
            take_r <= take_nxt;
            cnt_r <= cnt_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            addr_r <= addr_nxt;
            wd_r <= wd_nxt;
        end
    end

    assign mem_addr = addr_r;
    assign mem_rd = rd_r;
    assign mem_wr = wr_r;
    assign mem_wdata = wd_r;
    assign acc = a_r;
    assign cc = cc_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_imm;
        @(posedge clk) disable iff (reset)
        (state_r == S_OPC && mode_w == M_IMM && op_w < OP_ZERO)
        |=> (rd_r && addr_r == $past(pc_r)) ##1 state_r == S_EXEC;
    endproperty
    a_imm: assert property (p_imm) else $error("imm fetch");

    property p_dirs;
        @(posedge clk) disable iff (reset)
        (state_r == S_A1 && mode_w == M_DIRS && op_w < OP_ZERO)
        |=> rd_r && addr_r == {8'h00, $past(mem_rdata)};
    endproperty
    a_dirs: assert property (p_dirs) else $error("dir short");

    property p_dirl;
        @(posedge clk) disable iff (reset)
        (state_r == S_A2 && mode_w == M_DIRL && op_w < OP_ZERO)
        |=> addr_r == {$past(tmp_r), $past(mem_rdata)};
    endproperty
    a_dirl: assert property (p_dirl) else $error("dir long");

    property p_idxs;
        @(posedge clk) disable iff (reset)
        (state_r == S_A1 && mode_w == M_IDXS && op_w < OP_ZERO)
        |=> addr_r == {8'h00, $past(idx_w)} + {8'h00, $past(mem_rdata)};
    endproperty
    a_idxs: assert property (p_idxs) else $error("idx short");

    property p_inds;
        @(posedge clk) disable iff (reset)
        (state_r == S_P1 && mode_w == M_INDS && op_w < OP_ZERO)
        |=> addr_r == {8'h00, $past(mem_rdata)};
    endproperty
    a_inds: assert property (p_inds) else $error("ind short");

    property p_bitcmp;
        @(posedge clk) disable iff (reset)
        (state_r == S_EXEC && op_w == OP_BIT_CMP)
        |=> a_r == $past(a_r) && cc_r[CC_Z] == ($past(and_w) == 8'h00)
        && cc_r[CC_N] == $past(and_w[DW-1]);
    endproperty
    a_bitcmp: assert property (p_bitcmp) else $error("bit compare");

    property p_bit;
        @(posedge clk) disable iff (reset)
        (state_r == S_BIT) |=> cc_r[CC_C] == $past(bit_w)
        && take_r == ($past(bit_w) == $past(ir_r[F_SENSE]));
    endproperty
    a_bit: assert property (p_bit) else $error("bit test");

    property p_jri;
        @(posedge clk) disable iff (reset)
        (state_r == S_OPC && op_w == OP_JRI)
        |=> take_r == ($past(irq_lvl_r) ^ $past(mem_rdata[F_JR_LOW]));
    endproperty
    a_jri: assert property (p_jri) else $error("pin branch");

    property p_zero_a;
        @(posedge clk) disable iff (reset)
        (state_r == S_OPC && op_w == OP_ZERO && mode_w == M_IMM)
        |=> a_r == 8'h00 && !cc_r[CC_N] && cc_r[CC_Z];
    endproperty
    a_zero_a: assert property (p_zero_a) else $error("clear");

    property p_int_ret;
        @(posedge clk) disable iff (reset)
        (state_r == S_POP && cnt_r == POP_LAST)
        |=> pc_r[7:0] == $past(mem_rdata) && state_r == S_FETCH;
    endproperty
    a_int_ret: assert property (p_int_ret) else $error("stack return");

endmodule : coad_core

// >>> hw/coad_ea_add.sv
`timescale 1ns/1ps
module coad_ea_add #(
    parameter int AW = 16, // Address width
    parameter int IW = 8 // Index register width
) (
    input wire logic [IW-1:0] idx, // Selected index register
    input wire logic [AW-1:0] off, // Offset from the instruction
    output logic [AW-1:0] ea // Effective address
);
    // Unsigned index plus offset, wraps in the address space
    assign ea = off + {{(AW-IW){1'b0}}, idx};
endmodule : coad_ea_add

// >>> hw/coad_pkg.sv
package coad_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int AW = 16;
    localparam int DW = 8;

    // ------------------------------------------------------------
    // Opcode layout: op in high nibble, mode in low bits
    // ------------------------------------------------------------
    localparam int OP_HI = 7;
    localparam int OP_LO = 4;
    localparam int MODE_HI = 2;
    localparam int F_YSEL = 3;
    localparam int F_SENSE = 3;
    localparam int F_JR_LOW = 0;

    typedef enum logic [3:0] {
        OP_LD = 4'h0,
        OP_CP = 4'h1,
        OP_BIT_CMP = 4'h2,
        OP_AND = 4'h3,
        OP_OR = 4'h4,
        OP_XOR = 4'h5,
        OP_ADD = 4'h6,
        OP_ADC = 4'h7,
        OP_SUB = 4'h8,
        OP_SBC = 4'h9,
        OP_ZERO = 4'hA,
        OP_LDX = 4'hB,
        OP_LDY = 4'hC,
        OP_BTJ = 4'hD,
        OP_JRI = 4'hE,
        OP_RET = 4'hF
    } coad_op_t;

    typedef enum logic [2:0] {
        M_IMM = 3'h0,
        M_DIRS = 3'h1,
        M_DIRL = 3'h2,
        M_IDX0 = 3'h3,
        M_IDXS = 3'h4,
        M_IDXL = 3'h5,
        M_INDS = 3'h6,
        M_INDL = 3'h7
    } coad_mode_t;

    typedef enum logic [3:0] {
        S_FETCH = 4'h0,
        S_WAIT = 4'h1,
        S_OPC = 4'h2,
        S_A1 = 4'h3,
        S_A2 = 4'h4,
        S_P1 = 4'h5,
        S_P2 = 4'h6,
        S_BIT = 4'h7,
        S_REL = 4'h8,
        S_EXEC = 4'h9,
        S_POP = 4'hA
    } coad_state_t;

    // ------------------------------------------------------------
    // Condition code bits and reset values
    // ------------------------------------------------------------
    localparam int CC_C = 0;
    localparam int CC_Z = 1;
    localparam int CC_N = 2;
    localparam int CC_I = 3;
    localparam int CC_H = 4;
    localparam logic [7:0] CC_RST = 8'h08;
    localparam logic [7:0] SP_RST = 8'hFF;
    localparam logic [7:0] STK_HI = 8'h01;
    localparam logic [15:0] PC_RST = 16'h0000;

    // ------------------------------------------------------------
    // Stack pop order on interrupt return
    // ------------------------------------------------------------
    localparam logic [2:0] POP_CC = 3'h0;
    localparam logic [2:0] POP_A = 3'h1;
    localparam logic [2:0] POP_X = 3'h2;
    localparam logic [2:0] POP_PCH = 3'h3;
    localparam logic [2:0] POP_LAST = 3'h4;

endpackage : coad_pkg

// >>> tb/coad_mem_model.sv
`timescale 1ns/1ps
module coad_mem_model (
    input wire logic clk, // Core clock
    input wire logic [15:0] addr, // Byte address
    input wire logic rd, // Read strobe
    input wire logic wr, // Write strobe
    input wire logic [7:0] wdata, // Write data
    output logic [7:0] rdata // Read data, cycle after strobe
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_r = 8'h5A;
    logic ans_r = 1'b0;
    // Answer in the cycle after the strobe, never stall
    always @(posedge clk) begin
        ans_r <= rd;
        if (rd) begin
            last_r <= mem[addr];
        end
        if (wr) begin
            mem[addr] <= wdata;
        end
    end
    // Outside the answer cycle the bus shows a changed value
    assign rdata = ans_r ? last_r : ~last_r;
endmodule : coad_mem_model

// >>> tb/test_cpu_operand_addressing_decode.sv
`timescale 1ns/1ps
module test_cpu_operand_addressing_decode;
    import coad_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic irq_pin = 1'b0;
    logic irq_lvl = 1'b0;
    logic rd, wr;
    logic [7:0] rdata, wdata, acc, cc, a_e, c_e, x_e, v, m, sp_e;
    logic [15:0] addr, pc, w;
    int seed = 36506;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int i;

    // ----------------------------------------------------------------
    // Clock, pin drive, cycle ceiling
    // ----------------------------------------------------------------
    always #2 clk = ~clk;
    // Pin level and timeout on the rising edge
    always @(posedge clk) begin
        irq_pin <= irq_lvl;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            test_done();
        end
    end

    coad_core #(
        .PC_START(16'h8000)
    ) DUT (
        .clk(clk), .reset(reset), .irq_pin(irq_pin),
        .mem_rdata(rdata), .mem_addr(addr), .mem_rd(rd),
        .mem_wr(wr), .mem_wdata(wdata), .acc(acc), .cc(cc)
    );
    coad_mem_model MEM (
        .clk(clk), .addr(addr), .rd(rd), .wr(wr),
        .wdata(wdata), .rdata(rdata)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [7:0] nz(input logic [7:0] r);
        logic [7:0] c;
        c = c_e;
        c[CC_N] = r[7];
        c[CC_Z] = (r == 8'h00);
        return c;
    endfunction : nz
    function automatic logic [15:0] add_exp(input logic [7:0] a, b,
                                            input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] c;
        s = {1'b0, a} + {1'b0, b} + 9'(ci);
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci);
        c = nz(s[7:0]);
        c[CC_H] = h[4];
        c[CC_C] = s[8];
        return {s[7:0], c};
    endfunction : add_exp
    task automatic put(input logic [7:0] b);
        MEM.mem[pc] = b;
        pc = pc + 16'h0001;
    endtask : put
    task automatic op1(input logic [7:0] o, input logic [7:0] b);
        put(o);
        put(b);
    endtask : op1
    task automatic op2(input logic [7:0] o, input logic [15:0] b);
        put(o);
        put(b[15:8]);
        put(b[7:0]);
    endtask : op2
    task automatic ld(input logic [7:0] b);
        a_e = b;
        c_e = nz(b);
    endtask : ld
    // Wait for the next opcode fetch, then compare A and flags
    task automatic fin();
        int n;
        n = 0;
        while (!(rd === 1'b1 && addr === pc) && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(16'(n < 40), 16'h0001);
        chk({acc, cc}, {a_e, c_e});
    endtask : fin
    task automatic br(input logic tk);
        pc = tk ? pc + 16'h0004 : pc;
        fin();
    endtask : br

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        pc = 16'h8000;
        a_e = 8'h00;
        c_e = CC_RST;
        sp_e = SP_RST;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 8; i++) begin
            irq_lvl = i[1];
            ld(8'($random(seed)));
            op1(8'h00, a_e);
            fin();
            m = 8'($random(seed));
            v = 8'($random(seed));
            MEM.mem[{8'h00, m}] = v;
            op1(8'h01, m);
            ld(v);
            fin();
            w = 16'($random(seed)) & 16'h3FFF;
            MEM.mem[w] = v + 8'h11;
            op2(8'h02, w);
            ld(v + 8'h11);
            fin();
            // Index loads, then X and Y based operands
            x_e = (i == 0) ? 8'hFF : 8'($random(seed));
            op1(8'hB0, x_e);
            c_e = nz(x_e);
            fin();
            MEM.mem[{8'h00, x_e}] = v ^ 8'h5A;
            put(8'h03);
            ld(v ^ 8'h5A);
            fin();
            m = (i == 0) ? 8'hFF : 8'($random(seed));
            MEM.mem[16'(x_e) + 16'(m)] = v + 8'h01;
            op1(8'h04, m);
            ld(v + 8'h01);
            fin();
            x_e = 8'($random(seed));
            op1(8'hC0, x_e);
            c_e = nz(x_e);
            fin();
            MEM.mem[w + 16'(x_e)] = v + 8'h02;
            op2(8'h0D, w);
            ld(v + 8'h02);
            fin();
            // Pointer in page zero, short and long
            m = m & 8'h7F;
            MEM.mem[{8'h00, m}] = ~m;
            MEM.mem[{8'h00, ~m}] = v + 8'h03;
            op1(8'h06, m);
            ld(v + 8'h03);
            fin();
            w = {3'b001, 13'($random(seed))};
            MEM.mem[{8'h00, m}] = w[15:8];
            MEM.mem[{8'h00, m + 8'h01}] = w[7:0];
            MEM.mem[w] = v + 8'h04;
            op1(8'h07, m);
            ld(v + 8'h04);
            fin();
            // Bit compare, add, add with carry
            op1(8'h20, v);
            c_e = nz(a_e & v);
            fin();
            op1(8'h60, m);
            {a_e, c_e} = add_exp(a_e, m, 1'b0);
            fin();
            op1(8'h70, v);
            {a_e, c_e} = add_exp(a_e, v, c_e[CC_C]);
            fin();
            // Logic, compare and subtract on immediates
            op1(8'h30, m);
            ld(a_e & m);
            fin();
            op1(8'h40, v);
            ld(a_e | v);
            fin();
            op1(8'h50, v);
            ld(a_e ^ v);
            fin();
            op1(8'h10, m);
            c_e[CC_C] = (a_e < m);
            c_e = nz(a_e - m);
            fin();
            op1(8'h80, v);
            c_e[CC_C] = (a_e < v);
            ld(a_e - v);
            fin();
            op1(8'h90, m);
            w = {8'h00, a_e} - {8'h00, m} - 16'(c_e[CC_C]);
            c_e[CC_C] = w[8];
            ld(w[7:0]);
            fin();
            // Clear memory, then clear A
            MEM.mem[{8'h00, m}] = 8'hFF;
            op1(8'hA1, m);
            c_e[CC_N] = 1'b0;
            c_e[CC_Z] = 1'b1;
            fin();
            chk(16'(MEM.mem[{8'h00, m}]), 16'h0000);
            put(8'hA0);
            a_e = 8'h00;
            fin();
            // Bit test branch and pin level branch
            MEM.mem[16'h0040] = m;
            op1({4'hD, i[0], v[2:0]}, 8'h40);
            put(8'h04);
            c_e[CC_C] = m[v[2:0]];
            br(m[v[2:0]] == i[0]);
            op1({7'h70, v[7]}, 8'h04);
            br(i[1] ^ v[7]);
            // Return pops flags, A, X and the program counter
            ld(8'($random(seed)));
            c_e = 8'($random(seed)) & 8'h1F;
            w = pc + 16'h0010;
            MEM.mem[{8'h01, sp_e + 8'h01}] = c_e;
            MEM.mem[{8'h01, sp_e + 8'h02}] = a_e;
            MEM.mem[{8'h01, sp_e + 8'h03}] = x_e;
            MEM.mem[{8'h01, sp_e + 8'h04}] = w[15:8];
            MEM.mem[{8'h01, sp_e + 8'h05}] = w[7:0];
            sp_e = sp_e + 8'h05;
            put(8'hF0);
            pc = w;
            fin();
            $display("pass %0d done", i);
        end
        test_done();
    end
endmodule : test_cpu_operand_addressing_decode
